// File: inc/serial2_pkg.sv
// package: register map, field positions and reset values of the serial channel
package serial2_pkg;

   // ---------------------------------------------------------------
   // register offsets (byte addresses on the special function bus)
   // ---------------------------------------------------------------
   localparam logic [15:0] ASYNC_MODE_ADDR    = 16'hff70;  // async_mode_register
   localparam logic [15:0] RX_ERR_STATUS_ADDR = 16'hff71;  // receive_error_status
   localparam logic [15:0] RX_BUFFER_ADDR     = 16'hff72;  // receive_buffer
   localparam logic [15:0] BAUD_CTRL_ADDR     = 16'hff73;  // baud generator control
   localparam logic [15:0] SYNC_CTRL_ADDR     = 16'hff74;  // sync_mode_control
   localparam logic [15:0] SYNC_SHIFT_ADDR    = 16'hff75;  // sync_shift_register

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] ASYNC_MODE_RST = 8'h00;
   localparam logic [7:0] RX_ERR_RST     = 8'h00;
   localparam logic [7:0] BAUD_CTRL_RST  = 8'h00;
   localparam logic [7:0] SYNC_CTRL_RST  = 8'h00;
   localparam logic [7:0] SHIFT_RST      = 8'h00;

   // ---------------------------------------------------------------
   // async_mode_register fields
   // ---------------------------------------------------------------
   localparam int TXE_BIT  = 7;   // transmit_enable_bit
   localparam int RXE_BIT  = 6;   // receive_enable_bit
   localparam int PSH_BIT  = 5;   // parity_select_high
   localparam int PSL_BIT  = 4;   // parity_select_low
   localparam int CL_BIT   = 3;   // char_length_bit, 1 = 8 bits
   localparam int SL_BIT   = 2;   // stop_length_bit, transmit side only
   localparam int ERROR_IRQ_SUPPRESS_BIT = 1;   // error_irq_suppress
   localparam int CSEL_BIT = 0;   // 1 = internal baud generator

   // parity select encodings
   localparam logic [1:0] PAR_NONE = 2'h0;
   localparam logic [1:0] PAR_ZERO = 2'h1;
   localparam logic [1:0] PAR_ODD  = 2'h2;
   localparam logic [1:0] PAR_EVEN = 2'h3;

   // ---------------------------------------------------------------
   // status, sync control and baud control fields
   // ---------------------------------------------------------------
   localparam int PE_BIT   = 2;   // parity error
   localparam int FE_BIT   = 1;   // framing error
   localparam int OVE_BIT  = 0;   // overrun error
   localparam int SRQ_BIT  = 7;   // receive_request_flag in status
   localparam int CSIE_BIT = 7;   // sync_enable_bit
   localparam int SCKI_BIT = 1;   // 1 = internal sync clock
   localparam int BAUD_K_LSB = 0; // divisor offset k, bits 3:0
   localparam int BAUD_N_LSB = 4; // prescale exponent n, bits 7:4

   // ---------------------------------------------------------------
   // timing counts
   // ---------------------------------------------------------------
   localparam logic [4:0] BIT_TICK_BASE = 5'h10;  // ticks per bit = base + k
   localparam logic [3:0] SYNC_BITS     = 4'h8;   // bits per 3-wire unit

endpackage : serial2_pkg

// File: rtl/serial2_channel.sv
// serial channel 2: asynchronous receiver and 3-wire synchronous shifter
//
// Contract
// - receive enable starts sampling the receive pin on the selected serial clock
// - low pin starts 5-bit counter; recheck at half bit; still low means start bit
// - after data, parity and one stop bit, load buffer and pulse receive complete
// - frames with errors still load the buffer; receive complete pulses unless the suppress bit is set
// - clearing receive enable mid-frame aborts; buffer, status, interrupts untouched
// - parity, framing, overrun set status flags and pulse receive error together
// - parity error when received parity disagrees with configured parity type
// - framing error when stop bit sampled low
// - overrun when a frame completes before the buffer was read
// - status clears on buffer read or next frame; new errors set again
// - parity select: none, zero unchecked, odd, even
// - suppress bit withholds receive complete on error frames
// - clock select bit: 0 external baud pin, 1 internal baud generator
// - 3-wire mode moves 8-bit units, one bit per clock, three lines
// - 3-wire shifts out on falling clock edge, captures on rising edge
// - after 8 bits shifting stops and receive request flag sets
// - shift write starts only if enabled and clock idle high
// - 7-bit characters read back with bit 7 zero
// - receiver checks only one stop bit
// - overrun recurs each frame until buffer read
`timescale 1ns/1ps
module serial2_channel
   import serial2_pkg::*;
(
   input  wire logic        sys_clk,                  // 250 MHz system clock
   input  wire logic        resetn,                   // async reset, active low
   input  wire logic [15:0] addr,                     // register address
   input  wire logic [7:0]  wdata,                    // register write data
   input  wire logic        wr,                       // write strobe
   input  wire logic        rd,                       // read strobe
   output logic      [7:0]  rdata,                    // read data, cycle after rd
   input  wire logic        rx_pin,                   // asynchronous receive pin
   input  wire logic        external_baud_clock_pin,  // external baud clock
   input  wire logic        sync_clock_line_in,       // clock line level
   output logic             sync_clock_line_out,      // clock line drive value
   output logic             sync_clock_line_oe,       // high while driving clock
   input  wire logic        sync_data_in,             // 3-wire data input
   output logic             sync_data_out,            // 3-wire data output
   output logic             receive_complete_irq,     // one-cycle pulse
   output logic             receive_error_irq,        // one-cycle pulse
   output logic             receive_request_flag      // 3-wire unit done, sticky
);

   // ---------------------------------------------------------------
   // types and declarations
   // ---------------------------------------------------------------
   typedef enum logic [4:0] {
      RX_IDLE   = 5'h01,
      RX_START  = 5'h02,
      RX_DATA   = 5'h04,
      RX_PARITY = 5'h08,
      RX_STOP   = 5'h10
   } rx_state_e;

   rx_state_e   rx_state_reg;
   logic [7:0]  async_mode_reg;
   logic [7:0]  baud_ctrl_reg;
   logic [7:0]  sync_ctrl_reg;
   logic [7:0]  rx_err_reg;
   logic [7:0]  rx_buf_reg;
   logic [7:0]  rx_shift_reg;
   logic [7:0]  sync_shift_reg;
   logic [4:0]  tick_cnt_reg;
   logic [3:0]  bit_cnt_reg;
   logic        rx_par_reg;
   logic        rx_full_reg;
   logic [14:0] pre_cnt_reg;
   logic        int_tick_reg;
   logic [2:0]  rx_sync_reg;
   logic [2:0]  ext_sync_reg;
   logic [2:0]  sck_sync_reg;
   logic [1:0]  si_sync_reg;
   logic        sync_busy_reg;
   logic        sck_int_reg;
   logic [3:0]  sync_cnt_reg;
   logic        frame_done;
   logic [2:0]  frame_err;
   logic        async_tick;
   logic        rx_level;
   logic [4:0]  bit_ticks;
   logic [1:0]  par_sel;
   logic [3:0]  char_bits;
   logic        rd_buf;
   logic        wr_shift;
   logic        sck_fall;
   logic        sck_rise;

   // address match, used by the control writes, buffer read, shift write and flag clear decodes, not by the read data path
   function automatic logic hit(input logic [15:0] a, input logic [15:0] target);
      hit = (a == target);
   endfunction : hit

   // ---------------------------------------------------------------
   // decode and derived settings
   // ---------------------------------------------------------------
   assign par_sel   = {async_mode_reg[PSH_BIT], async_mode_reg[PSL_BIT]};
   assign char_bits = async_mode_reg[CL_BIT] ? 4'h8 : 4'h7;
   assign bit_ticks = BIT_TICK_BASE + {1'b0, baud_ctrl_reg[BAUD_K_LSB +: 4]};
   assign rd_buf    = rd && hit(addr, RX_BUFFER_ADDR);
   assign wr_shift  = wr && hit(addr, SYNC_SHIFT_ADDR);
   assign rx_level  = rx_sync_reg[1];

   // internal generator or rising edge of the external pin feeds the counter
   assign async_tick = async_mode_reg[CSEL_BIT] ? int_tick_reg
                                                : (ext_sync_reg[1] && !ext_sync_reg[2]);

   // ---------------------------------------------------------------
   // input synchronisers
   // ---------------------------------------------------------------
   // only stage 1 and later are read by logic, stage 0 feeds stage 1 alone
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rx_sync_reg  <= 3'h7;
         ext_sync_reg <= 3'h0;
         sck_sync_reg <= 3'h7;
         si_sync_reg  <= 2'h0;
      end else begin
         rx_sync_reg  <= {rx_sync_reg[1:0], rx_pin};
         ext_sync_reg <= {ext_sync_reg[1:0], external_baud_clock_pin};
         sck_sync_reg <= {sck_sync_reg[1:0], sync_clock_line_in};
         si_sync_reg  <= {si_sync_reg[0], sync_data_in};
      end
   end

   // ---------------------------------------------------------------
   // internal baud prescaler: one-cycle tick every 2^n system clocks
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pre_cnt_reg  <= 15'h0000;
         int_tick_reg <= 1'b0;
      end else if (pre_cnt_reg >= ((15'h0001 << baud_ctrl_reg[BAUD_N_LSB +: 4]) - 15'h0001)) begin
         pre_cnt_reg  <= 15'h0000;
         int_tick_reg <= 1'b1;
      end else begin
         pre_cnt_reg  <= pre_cnt_reg + 15'h0001;
         int_tick_reg <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // control registers
   // ---------------------------------------------------------------
   // writes while a frame is in flight are not blocked; software avoids them
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         async_mode_reg <= ASYNC_MODE_RST;
         baud_ctrl_reg  <= BAUD_CTRL_RST;
         sync_ctrl_reg  <= SYNC_CTRL_RST;
      end else if (wr) begin
         if (hit(addr, ASYNC_MODE_ADDR)) async_mode_reg <= wdata;
         if (hit(addr, BAUD_CTRL_ADDR))  baud_ctrl_reg  <= wdata;
         if (hit(addr, SYNC_CTRL_ADDR))  sync_ctrl_reg  <= wdata;
      end
   end

   // ---------------------------------------------------------------
   // asynchronous receive sequencer
   // ---------------------------------------------------------------
   // the 5-bit counter counts serial ticks within one bit time
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rx_state_reg <= RX_IDLE;
         tick_cnt_reg <= 5'h00;
         bit_cnt_reg  <= 4'h0;
         rx_shift_reg <= SHIFT_RST;
         rx_par_reg   <= 1'b0;
      end else if (!async_mode_reg[RXE_BIT]) begin
         rx_state_reg <= RX_IDLE;
         tick_cnt_reg <= 5'h00;
      end else begin
         case (rx_state_reg)
            RX_IDLE: begin
               tick_cnt_reg <= 5'h00;
               if (!rx_level) rx_state_reg <= RX_START;
            end
            RX_START: begin
               if (async_tick) begin
                  if (tick_cnt_reg == (bit_ticks >> 1) - 5'h01) begin
                     tick_cnt_reg <= 5'h00;
                     bit_cnt_reg  <= 4'h0;
                     rx_par_reg   <= 1'b0;
                     rx_shift_reg <= 8'h00;
                     rx_state_reg <= rx_level ? RX_IDLE : RX_DATA;
                  end else begin
                     tick_cnt_reg <= tick_cnt_reg + 5'h01;
                  end
               end
            end
            RX_DATA: begin
               if (async_tick) begin
                  if (tick_cnt_reg == bit_ticks - 5'h01) begin
                     tick_cnt_reg <= 5'h00;
                     // lsb first; the parity sum takes the character bits here and the parity bit after them
                     rx_shift_reg[bit_cnt_reg[2:0]] <= rx_level;
                     rx_par_reg   <= rx_par_reg ^ rx_level;
                     bit_cnt_reg  <= bit_cnt_reg + 4'h1;
                     if (bit_cnt_reg == char_bits - 4'h1) begin
                        rx_state_reg <= (par_sel == PAR_NONE) ? RX_STOP : RX_PARITY;
                     end
                  end else begin
                     tick_cnt_reg <= tick_cnt_reg + 5'h01;
                  end
               end
            end
            RX_PARITY: begin
               if (async_tick) begin
                  if (tick_cnt_reg == bit_ticks - 5'h01) begin
                     tick_cnt_reg <= 5'h00;
                     rx_par_reg   <= rx_par_reg ^ rx_level;
                     rx_state_reg <= RX_STOP;
                  end else begin
                     tick_cnt_reg <= tick_cnt_reg + 5'h01;
                  end
               end
            end
            RX_STOP: begin
               // a single stop bit is checked whatever the transmit setting
               if (async_tick) begin
                  if (tick_cnt_reg == bit_ticks - 5'h01) begin
                     tick_cnt_reg <= 5'h00;
                     rx_state_reg <= RX_IDLE;
                  end else begin
                     tick_cnt_reg <= tick_cnt_reg + 5'h01;
                  end
               end
            end
            default: begin
               rx_state_reg <= RX_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // frame completion and error classification
   // ---------------------------------------------------------------
   assign frame_done = async_mode_reg[RXE_BIT] && (rx_state_reg == RX_STOP) && async_tick
                       && (tick_cnt_reg == bit_ticks - 5'h01);
   // odd parity wants an odd count of ones, so a zero sum is the error
   assign frame_err[PE_BIT]  = ((par_sel == PAR_ODD)  && !rx_par_reg)
                            || ((par_sel == PAR_EVEN) &&  rx_par_reg);
   assign frame_err[FE_BIT]  = !rx_level;
   assign frame_err[OVE_BIT] = rx_full_reg && !rd_buf;

   // ---------------------------------------------------------------
   // receive buffer, status and completion events
   // ---------------------------------------------------------------
   // a frame finishing in the same cycle as a buffer read wins over the clear
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rx_buf_reg           <= SHIFT_RST;
         rx_err_reg           <= RX_ERR_RST;
         rx_full_reg          <= 1'b0;
         receive_complete_irq <= 1'b0;
         receive_error_irq    <= 1'b0;
      end else if (frame_done) begin
         rx_buf_reg           <= rx_shift_reg;
         rx_err_reg           <= {5'h00, frame_err};
         rx_full_reg          <= 1'b1;
         receive_error_irq    <= |frame_err;
         receive_complete_irq <= !(|frame_err) || !async_mode_reg[ERROR_IRQ_SUPPRESS_BIT];
      end else begin
         receive_complete_irq <= 1'b0;
         receive_error_irq    <= 1'b0;
         if (rd_buf) begin
            rx_err_reg  <= RX_ERR_RST;
            rx_full_reg <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // 3-wire clock: internal toggles on the prescaler, external is sampled
   // ---------------------------------------------------------------
   assign sck_fall = sync_ctrl_reg[SCKI_BIT] ? (sck_int_reg && int_tick_reg)
                                             : (sck_sync_reg[2] && !sck_sync_reg[1]);
   assign sck_rise = sync_ctrl_reg[SCKI_BIT] ? (!sck_int_reg && int_tick_reg)
                                             : (!sck_sync_reg[2] && sck_sync_reg[1]);

   // ---------------------------------------------------------------
   // 3-wire shifter
   // ---------------------------------------------------------------
   // msb goes out on each fall, input bit enters lsb on each rise
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         sync_shift_reg <= SHIFT_RST;
         sync_busy_reg  <= 1'b0;
         sync_cnt_reg   <= 4'h0;
         sck_int_reg    <= 1'b1;
         sync_data_out  <= 1'b1;
      end else if (!sync_ctrl_reg[CSIE_BIT]) begin
         sync_busy_reg <= 1'b0;
         sck_int_reg   <= 1'b1;
         if (wr_shift) sync_shift_reg <= wdata;   // loaded but never starts later
      end else if (!sync_busy_reg) begin
         sck_int_reg <= 1'b1;
         // an external clock held low means the master is mid-unit
         if (wr_shift && (sync_ctrl_reg[SCKI_BIT] || sck_sync_reg[1])) begin
            sync_shift_reg <= wdata;
            sync_busy_reg  <= 1'b1;
            sync_cnt_reg   <= 4'h0;
         end
      end else begin
         if (sync_ctrl_reg[SCKI_BIT] && int_tick_reg) sck_int_reg <= !sck_int_reg;
         if (sck_fall) sync_data_out <= sync_shift_reg[7];
         if (sck_rise) begin
            sync_shift_reg <= {sync_shift_reg[6:0], si_sync_reg[1]};
            sync_cnt_reg   <= sync_cnt_reg + 4'h1;
            if (sync_cnt_reg == SYNC_BITS - 4'h1) sync_busy_reg <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // clock line drive and unit-done flag
   // ---------------------------------------------------------------
   // the flag clears on a shift read or write; a unit ending then keeps it set
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         sync_clock_line_out  <= 1'b1;
         sync_clock_line_oe   <= 1'b0;
         receive_request_flag <= 1'b0;
      end else begin
         sync_clock_line_out <= sck_int_reg;
         sync_clock_line_oe  <= sync_ctrl_reg[CSIE_BIT] && sync_ctrl_reg[SCKI_BIT];
         if (sync_busy_reg && sck_rise && (sync_cnt_reg == SYNC_BITS - 4'h1)) begin
            receive_request_flag <= 1'b1;
         end else if (wr_shift || (rd && hit(addr, SYNC_SHIFT_ADDR))) begin
            receive_request_flag <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // read data path, one cycle after the strobe; unmapped reads zero
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rdata <= 8'h00;
      end else if (rd) begin
         case (addr)
            ASYNC_MODE_ADDR:    rdata <= async_mode_reg;
            RX_ERR_STATUS_ADDR: rdata <= {receive_request_flag, rx_err_reg[6:0]};
            RX_BUFFER_ADDR:     rdata <= rx_buf_reg;
            BAUD_CTRL_ADDR:     rdata <= baud_ctrl_reg;
            SYNC_CTRL_ADDR:     rdata <= sync_ctrl_reg;
            SYNC_SHIFT_ADDR:    rdata <= sync_shift_reg;
            default:            rdata <= 8'h00;
         endcase
      end
   end

endmodule : serial2_channel

// File: tb/serial2_channel_props.sv
// checker: port-level timing relations of the serial channel
`timescale 1ns/1ps
module serial2_channel_chk
   import serial2_pkg::*;
(
   input wire logic        sys_clk,              // clock
   input wire logic        resetn,               // reset, active low
   input wire logic [15:0] addr,                 // bus address
   input wire logic [7:0]  wdata,                // bus write data
   input wire logic        wr,                   // write strobe
   input wire logic        receive_complete_irq, // frame done pulse
   input wire logic        receive_error_irq,    // frame error pulse
   input wire logic        receive_request_flag, // 3-wire unit done
   input wire logic        sync_clock_line_out,  // clock line drive
   input wire logic        sync_clock_line_oe,   // clock line enable
   input wire logic        sync_data_out         // 3-wire data out
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   logic [7:0] mode_reg;
   logic [7:0] sctl_reg;
   logic [3:0] rise_reg;
   // shadow the async mode and sync control registers as software wrote them
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         mode_reg <= ASYNC_MODE_RST;
         sctl_reg <= SYNC_CTRL_RST;
      end else if (wr) begin
         if (addr == ASYNC_MODE_ADDR) mode_reg <= wdata;
         if (addr == SYNC_CTRL_ADDR) sctl_reg <= wdata;
      end
   end
   // clock rises since the last shift write; a lost or extra bit shows in the count
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) rise_reg <= 4'h0;
      else if (wr && addr == SYNC_SHIFT_ADDR) rise_reg <= 4'h0;
      else if (sync_clock_line_oe && $rose(sync_clock_line_out)) rise_reg <= rise_reg + 4'h1;
   end
   property p_cmp_pulse; receive_complete_irq |=> !receive_complete_irq; endproperty
   a_cmp_pulse: assert property (p_cmp_pulse) else $error("complete pulse too long");
   property p_err_pulse; receive_error_irq |=> !receive_error_irq; endproperty
   a_err_pulse: assert property (p_err_pulse) else $error("error pulse too long");
   property p_err_cmp; receive_error_irq && !mode_reg[ERROR_IRQ_SUPPRESS_BIT] |-> receive_complete_irq; endproperty
   a_err_cmp: assert property (p_err_cmp) else $error("error frame without complete");
   property p_suppress; receive_error_irq && mode_reg[ERROR_IRQ_SUPPRESS_BIT] |-> !receive_complete_irq; endproperty
   a_suppress: assert property (p_suppress) else $error("complete not withheld");
   property p_rx_off; !mode_reg[RXE_BIT] && !$past(mode_reg[RXE_BIT], 2) |-> !(receive_complete_irq || receive_error_irq); endproperty
   a_rx_off: assert property (p_rx_off) else $error("irq while receiver off");
   // the line register trails the internal clock by one cycle, so it shows low the cycle after data moves
   property p_sout_fall; $changed(sync_data_out) && sync_clock_line_oe |=> !sync_clock_line_out; endproperty
   a_sout_fall: assert property (p_sout_fall) else $error("data moved outside clock low");
   property p_eight; $rose(receive_request_flag) |-> ##2 rise_reg == 4'h8; endproperty
   a_eight: assert property (p_eight) else $error("unit not eight clocks");
   property p_no_start; wr && addr == SYNC_SHIFT_ADDR && !sctl_reg[CSIE_BIT] |=> sync_clock_line_out [*4]; endproperty
   a_no_start: assert property (p_no_start) else $error("unit started while disabled");
   c_cmp: cover property (receive_complete_irq && !receive_error_irq);
   c_err: cover property (receive_error_irq);
   c_unit: cover property ($rose(receive_request_flag));
endmodule : serial2_channel_chk
bind serial2_channel serial2_channel_chk u_chk (.sys_clk, .resetn, .addr, .wdata, .wr, .receive_complete_irq,
   .receive_error_irq, .receive_request_flag, .sync_clock_line_out, .sync_clock_line_oe, .sync_data_out);

// File: tb/serial2_channel_tb_top.sv
// testbench: frame table, overrun, abort, 3-wire loopback, bus checks
`timescale 1ns/1ps
module serial2_channel_tb_top
   import serial2_pkg::*;
;
   typedef struct packed {logic [7:0] mode, data; logic par, stop; logic [7:0] rx_exp, st_exp;} row_s;
   localparam row_s ROWS [8] = '{
      '{8'h49, 8'ha5, 1'b0, 1'b1, 8'ha5, 8'h00},
      '{8'h48, 8'h5a, 1'b0, 1'b1, 8'h5a, 8'h00},
      '{8'h7d, 8'h3c, 1'b0, 1'b1, 8'h3c, 8'h00},
      '{8'h79, 8'h3c, 1'b1, 1'b1, 8'h3c, 8'h04},
      '{8'h69, 8'h01, 1'b1, 1'b1, 8'h01, 8'h04},
      '{8'h59, 8'hff, 1'b1, 1'b1, 8'hff, 8'h00},
      '{8'h41, 8'hff, 1'b0, 1'b1, 8'h7f, 8'h00},
      '{8'h4b, 8'h81, 1'b0, 1'b0, 8'h81, 8'h02}};
   logic        sys_clk = 1'b0;
   logic        resetn  = 1'b0;
   logic [15:0] addr    = 16'h0000;
   logic [7:0]  wdata   = 8'h00;
   logic        wr      = 1'b0;
   logic        rd      = 1'b0;
   logic [1:0]  ext_cnt = 2'h0;
   logic [7:0]  rdata;
   logic        rx_pin, sck_out, sck_oe, sdo, cmp_irq, err_irq, srq;
   wire logic   sck_line = sck_oe ? sck_out : 1'b1; // pulled up while nobody drives
   int          bad_count = 0, n_tests = 0, cyc = 0, cmp_cnt = 0, err_cnt = 0, c0, e0;
   serial2_channel u_dut (.sys_clk, .resetn, .addr, .wdata, .wr, .rd, .rdata, .rx_pin,
      .external_baud_clock_pin(ext_cnt[1]), .sync_clock_line_in(sck_line), .sync_clock_line_out(sck_out),
      .sync_clock_line_oe(sck_oe), .sync_data_in(sdo), .sync_data_out(sdo), .receive_complete_irq(cmp_irq),
      .receive_error_irq(err_irq), .receive_request_flag(srq));
   serial2_far_end #(.BIT_CYC(64)) u_far (.sys_clk, .rx_line(rx_pin));
   always #2 sys_clk = ~sys_clk;
   // external baud clock rises every 4 cycles, same bit time as the internal divider
   always @(posedge sys_clk) ext_cnt <= ext_cnt + 2'h1;
   // pulses are counted here so no frame's pulse can slip past a busy task
   always @(posedge sys_clk) begin
      cmp_cnt <= cmp_cnt + int'(cmp_irq);
      err_cnt <= err_cnt + int'(err_irq);
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         bad_count++;
         give_verdict();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wreg(input logic [15:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge sys_clk);
      wr <= 1'b0;
      @(posedge sys_clk);
   endtask : wreg
   // read data appears the cycle after the strobe and holds until the next read
   task automatic rreg(input logic [15:0] a, input logic [7:0] e);
      addr <= a;
      rd <= 1'b1;
      @(posedge sys_clk);
      rd <= 1'b0;
      @(posedge sys_clk);
      chk(rdata, e);
   endtask : rreg
   task automatic give_verdict();
      if (bad_count == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : give_verdict
   initial begin
      repeat (5) @(posedge sys_clk);
      resetn <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rreg(ASYNC_MODE_ADDR, ASYNC_MODE_RST);
      rreg(RX_ERR_STATUS_ADDR, RX_ERR_RST);
      wreg(16'hff7f, 8'h5a);
      rreg(16'hff7f, 8'h00);
      wreg(BAUD_CTRL_ADDR, 8'h20);
      foreach (ROWS[i]) begin
         c0 = cmp_cnt;
         e0 = err_cnt;
         wreg(ASYNC_MODE_ADDR, ROWS[i].mode);
         rreg(ASYNC_MODE_ADDR, ROWS[i].mode);
         u_far.send(ROWS[i].data, ROWS[i].mode[CL_BIT], |ROWS[i].mode[PSH_BIT:PSL_BIT], ROWS[i].par, ROWS[i].stop);
         chk(8'(err_cnt - e0), {7'h0, ROWS[i].st_exp != 8'h00});
         chk(8'(cmp_cnt - c0), {7'h0, !(ROWS[i].st_exp != 8'h00 && ROWS[i].mode[ERROR_IRQ_SUPPRESS_BIT])});
         rreg(RX_ERR_STATUS_ADDR, ROWS[i].st_exp);
         rreg(RX_BUFFER_ADDR, ROWS[i].rx_exp);
      end
      // a low stop bit can pass for a new start bit; drop the receiver before the next frames
      wreg(ASYNC_MODE_ADDR, 8'h09);
      wreg(ASYNC_MODE_ADDR, 8'h49);
      u_far.send(8'h11, 1'b1, 1'b0, 1'b0, 1'b1);
      u_far.send(8'h22, 1'b1, 1'b0, 1'b0, 1'b1);
      rreg(RX_ERR_STATUS_ADDR, 8'h01);
      u_far.send(8'h33, 1'b1, 1'b0, 1'b0, 1'b1);
      rreg(RX_ERR_STATUS_ADDR, 8'h01);
      rreg(RX_BUFFER_ADDR, 8'h33);
      rreg(RX_ERR_STATUS_ADDR, 8'h00);
      c0 = cmp_cnt + err_cnt;
      fork
         u_far.send(8'h44, 1'b1, 1'b0, 1'b0, 1'b1);
         begin
            repeat (300) @(posedge sys_clk);
            wreg(ASYNC_MODE_ADDR, 8'h09);
         end
      join
      chk(8'(cmp_cnt + err_cnt - c0), 8'h00);
      rreg(RX_BUFFER_ADDR, 8'h33);
      wreg(ASYNC_MODE_ADDR, 8'h00);
      wreg(SYNC_CTRL_ADDR, 8'h02);
      wreg(SYNC_SHIFT_ADDR, 8'h5a);
      wreg(SYNC_CTRL_ADDR, 8'h82);
      repeat (200) @(posedge sys_clk);
      chk({7'h0, srq}, 8'h00);
      wreg(SYNC_SHIFT_ADDR, 8'hc3);
      for (int i = 0; i < 400 && srq !== 1'b1; i++) @(posedge sys_clk);
      rreg(RX_ERR_STATUS_ADDR, 8'h80);
      rreg(SYNC_SHIFT_ADDR, 8'hc3);
      rreg(RX_ERR_STATUS_ADDR, 8'h00);
      give_verdict();
   end
endmodule : serial2_channel_tb_top

// File: tb/serial2_far_end.sv
// far-end model: remote transmitter driving the receive pin
`timescale 1ns/1ps
module serial2_far_end #(
   parameter int BIT_CYC = 64  // sys_clk cycles per bit
) (
   input wire logic sys_clk,   // clock
   output logic     rx_line    // receive pin drive
);
   initial rx_line = 1'b1;
   // one bit held for a full bit time, changed just after an edge
   task automatic put(input logic b);
      rx_line <= b;
      repeat (BIT_CYC) @(posedge sys_clk);
   endtask : put
   // start, lsb first character, optional parity, one stop, then idle long enough
   task automatic send(input logic [7:0] d, input logic eight, input logic has_par, input logic par, input logic stop);
      put(1'b0);
      for (int i = 0; i < (eight ? 8 : 7); i++) put(d[i]);
      if (has_par) put(par);
      put(stop);
      put(1'b1);
      put(1'b1);
   endtask : send
endmodule : serial2_far_end
